// file: inc/ddm_defines.svh
// constants for the ddr4 mode readout, gear-down and power-save block
`ifndef DDM_DEFINES_SVH
`define DDM_DEFINES_SVH
// clock period in ns
`define DDM_CLK_NS 10
// readout locations, selected by bank address
`define DDM_LOC0 2'h0
`define DDM_LOC1 2'h1
`define DDM_LOC2 2'h2
`define DDM_LOC3 2'h3
// readout pages and read format in mode register 3
`define DDM_PAGE2 2'h2
`define DDM_PAGE3 2'h3
`define DDM_FMT_SERIAL 2'h0
// mode register bit positions
`define DDM_MR3_MPR_ON 2
`define DDM_MR3_GEAR 3
`define DDM_MR3_TEMP 5
`define DDM_MR4_MPSM 1
`define DDM_MR4_ABORT 9
// reset value of every mode register
`define DDM_MR_RST 14'h0000
// times in ns, cycles rounded up (least times)
`define DDM_TMPED_NS 40
`define DDM_TXMP_NS 200
`define DDM_TXS_NS 270
`define DDM_TXSA_NS 100
`define DDM_CYC(ns) ((ns + `DDM_CLK_NS - 1) / `DDM_CLK_NS)
// gear command delay, already in clocks
`define DDM_GEAR_CMD_CYC 24
// temperature refresh age, longest time, rounded down
`define DDM_TEMP_MS 32
`define DDM_TEMP_CYC ((`DDM_TEMP_MS * 1000000) / `DDM_CLK_NS)
`endif

// file: inc/ddm_pkg.sv
// types for the ddr4 mode readout, gear-down and power-save block
package ddm_pkg;
  // command and control pins, sampled on clk
  typedef struct packed {
    logic        csN;
    logic        actN;
    logic        rasN;
    logic        casN;
    logic        weN;
    logic        cke;
    logic        odt;
    logic        bg0;
    logic [1:0]  ba;
    logic [13:0] addr;
  } ddm_cmd_t;
  // readout answer
  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } ddm_rd_t;
  // maximum power saving states
  typedef enum logic [1:0] {MP_OFF, MP_ENTRY, MP_ON, MP_EXIT} ddm_mpsm_t;
endpackage : ddm_pkg

// file: hdl/ddm_mode_ctrl.sv
// ddr4 mode readout, gear-down and maximum power saving logic
// Functional notes
// RL1 - page 2 mirrors programmed mode settings
// RL2 - loc0 bits 4:3 give refresh rate
// RL3 - temp status refreshed, at most 32ms old
// RL4 - temp readout off freezes status bits
// RL5 - page 3 bit0 one except loc3
// RL6 - pages 1-3 read in serial format only
// RL7 - reset starts in 1N half rate
// RL8 - gear-down samples cs/cke/odt on sync edge
// RL9 - host sends gear MRS then even sync
// RL10 - 2N starts after gear command delay
// RL11 - host programs even latencies for 2N
// RL12 - 1N self refresh exit waits exit delay
// RL13 - self refresh and power save force 1N
// RL14 - exit delay picks abort time by MR4 A9
// RL15 - host enters power save by MRS
// RL16 - host disables parity, CAL, gear first
// RL17 - power save ignores all but exit, reset
// RL18 - after entry delay only cs, cke count
// RL19 - host keeps clock valid after entry
// RL20 - cs high at cke rise stays in mode
// RL21 - cs low at cke rise starts exit
// RL22 - host restarts clock before exit
// RL23 - host sends deselects during exit delay
// RL24 - exit clears MR4 power save bit
// RL25 - page 2 tracks later MRS updates
`include "ddm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ddm_mode_ctrl #(
  parameter int TEMP_CYC = `DDM_TEMP_CYC  // temp refresh period
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire ddm_pkg::ddm_cmd_t cmd,
  input  wire logic [1:0]       tempRate,
  output var  ddm_pkg::ddm_rd_t rdOut,
  output var  logic             gearDown2n,
  output var  logic             mpsmOn,
  output var  logic             cmdAccept,
  output var  logic             ckeLatched,
  output var  logic             odtLatched,
  output var  logic             exitBusy
);
  import ddm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // constants
  localparam logic [15:0] TMPED = 16'(`DDM_CYC(`DDM_TMPED_NS));
  localparam logic [15:0] TXMP  = 16'(`DDM_CYC(`DDM_TXMP_NS));
  localparam logic [15:0] TXS   = 16'(`DDM_CYC(`DDM_TXS_NS));
  localparam logic [15:0] TXSA  = 16'(`DDM_CYC(`DDM_TXSA_NS));
  localparam logic [15:0] GEARD = 16'(`DDM_GEAR_CMD_CYC);
  localparam logic [21:0] TEMPC = 22'(TEMP_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [13:0] mr_ff [0:6];       // mode register copies
  logic        gearArm_ff;        // gear MRS seen, waiting sync
  logic        gearPar_ff;        // odd distance from gear MRS
  logic        gearWait_ff;       // sync seen, delay running
  logic [15:0] gearCnt_ff;        // gear command delay count
  logic        gearOn_ff;         // 2N active
  logic        phase_ff;          // free toggling clock phase
  logic        syncPhase_ff;      // phase captured at sync
  logic        srOn_ff;           // in self refresh
  logic [15:0] xsCnt_ff;          // self refresh exit delay
  ddm_mpsm_t   mpState_ff;        // power save state
  logic [15:0] mpCnt_ff;          // entry / exit delay
  logic        ckePrev_ff;        // cke last clock
  logic [1:0]  tempStat_ff;       // refresh rate status
  logic [21:0] tempCnt_ff;        // temp update timer
  ddm_rd_t     rdOut_ff;
  logic        cmdAccept_ff;
  logic        ckeLat_ff;
  logic        odtLat_ff;
  logic        mpsmOn_ff;         // power save flag, one clock behind
  logic        exitBusy_ff;       // exit delay flag, one clock behind

  ////////////////////////////////////////////////////////////////////////
  // command decode
  wire       sel    = !cmd.csN;
  wire       isMrs  = sel & cmd.actN & !cmd.rasN & !cmd.casN & !cmd.weN;
  wire       isRd   = sel & cmd.actN & cmd.rasN & !cmd.casN & cmd.weN;
  wire       isNop  = sel & cmd.actN & cmd.rasN & cmd.casN & cmd.weN;
  wire       isSre  = sel & cmd.actN & !cmd.rasN & !cmd.casN & cmd.weN
                      & !cmd.cke;
  wire [2:0] mrSel  = {cmd.bg0, cmd.ba};
  // in 2N only the edge aligned by sync is looked at
  wire       edgeOk = !gearOn_ff | (phase_ff == syncPhase_ff); // RL8
  // commands are dropped while any mode blocks them
  wire       live   = edgeOk & (mpState_ff == MP_OFF) & !srOn_ff   // RL17
                      & !gearWait_ff & (xsCnt_ff == 16'h0000);   // RL10
  wire       take   = live & sel;
  wire       mrWe   = live & isMrs & (mrSel != 3'h7);
  wire       ckeRise = cmd.cke & !ckePrev_ff;
  wire       mpDone = (mpState_ff == MP_EXIT) & (mpCnt_ff == 16'h0000);
  wire [13:0] mr0 = mr_ff[0];
  wire [13:0] mr1 = mr_ff[1];
  wire [13:0] mr2 = mr_ff[2];
  wire [13:0] mr3 = mr_ff[3];
  wire [13:0] mr4 = mr_ff[4];
  wire [13:0] mr5 = mr_ff[5];
  wire [13:0] mr6 = mr_ff[6];

  ////////////////////////////////////////////////////////////////////////
  // readout data, built from the live register copies
  wire [7:0] p2l0 = {3'h0, tempStat_ff, mr2[12], mr2[10:9]};   // RL2
  wire [7:0] p2l1 = {mr6[6:0], mr3[`DDM_MR3_GEAR]};            // RL1
  wire [7:0] p2l2 = {mr0[6:4], mr0[2], 1'b0, mr2[5:3]};        // RL1
  wire [7:0] p2l3 = {mr1[10:8], mr5[8:6], mr1[2:1]};           // RL1
  wire [7:0] p2Sel = (cmd.ba == `DDM_LOC0) ? p2l0 :
                     (cmd.ba == `DDM_LOC1) ? p2l1 :
                     (cmd.ba == `DDM_LOC2) ? p2l2 : p2l3;        // RL25
  // vendor page: upper bits read as zero
  wire [7:0] p3Sel = {7'h00, cmd.ba != `DDM_LOC3};             // RL5
  wire       mprOn = mr3[`DDM_MR3_MPR_ON];
  wire       serial = mr3[12:11] == `DDM_FMT_SERIAL;           // RL6
  wire       rdHit = live & isRd & mprOn & serial;
  wire [7:0] nxt_rdData = (mr3[1:0] == `DDM_PAGE2) ? p2Sel :
                          (mr3[1:0] == `DDM_PAGE3) ? p3Sel : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // mode register copies; power save exit clears its own bit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 7; i++)
        mr_ff[i] <= `DDM_MR_RST;
    end
    else
    begin
      if (mrWe)
        mr_ff[mrSel] <= cmd.addr;                               // RL25
      if (mpDone)
        mr_ff[4][`DDM_MR4_MPSM] <= 1'b0;                        // RL24
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gear-down: MRS, then sync on an even distance, then delay
  wire gearMrs  = mrWe & (mrSel == 3'h3) & cmd.addr[`DDM_MR3_GEAR];
  wire syncSeen = gearArm_ff & isNop & !gearPar_ff;            // RL9
  wire forceOne = (live & isSre) | (mpState_ff != MP_OFF);     // RL13
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gearArm_ff   <= 1'b0;
      gearPar_ff   <= 1'b0;
      gearWait_ff  <= 1'b0;
      gearCnt_ff   <= 16'h0000;
      gearOn_ff    <= 1'b0;                                     // RL7
      phase_ff     <= 1'b0;
      syncPhase_ff <= 1'b0;
    end
    else
    begin
      phase_ff   <= !phase_ff;
      gearPar_ff <= gearMrs | !gearPar_ff;
      if (forceOne)
      begin
        // internal fall back to 1N
        gearArm_ff  <= 1'b0;
        gearWait_ff <= 1'b0;
        gearOn_ff   <= 1'b0;                                    // RL13
      end
      else if (gearMrs)
        gearArm_ff <= 1'b1;
      else if (syncSeen)
      begin
        gearArm_ff   <= 1'b0;
        gearWait_ff  <= 1'b1;
        gearCnt_ff   <= GEARD;
        syncPhase_ff <= phase_ff;                               // RL8
      end
      else if (gearWait_ff)
      begin
        gearCnt_ff <= gearCnt_ff - 16'h0001;
        if (gearCnt_ff == 16'h0001)
        begin
          gearWait_ff <= 1'b0;
          gearOn_ff   <= 1'b1;                                  // RL10
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self refresh and its exit delay
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      srOn_ff  <= 1'b0;
      xsCnt_ff <= 16'h0000;
    end
    else if (srOn_ff)
    begin
      if (cmd.cke)
      begin
        srOn_ff  <= 1'b0;
        // abort exit is shorter when enabled
        xsCnt_ff <= mr4[`DDM_MR4_ABORT] ? TXSA : TXS;           // RL14
      end
    end
    else if (live & isSre)
      srOn_ff <= 1'b1;
    else if (xsCnt_ff != 16'h0000)
      xsCnt_ff <= xsCnt_ff - 16'h0001;                          // RL12
  end

  ////////////////////////////////////////////////////////////////////////
  // maximum power saving; pins are synchronous here, so the cke
  // rise is seen on clk rather than on the pin itself
  wire mpsmMrs = mrWe & (mrSel == 3'h4) & cmd.addr[`DDM_MR4_MPSM];
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mpState_ff <= MP_OFF;
      mpCnt_ff   <= 16'h0000;
      ckePrev_ff <= 1'b0;
    end
    else
    begin
      ckePrev_ff <= cmd.cke;
      case (mpState_ff)
        MP_OFF:
          if (mpsmMrs)
          begin
            mpState_ff <= MP_ENTRY;
            mpCnt_ff   <= TMPED;
          end
        MP_ENTRY:
          // only deselects expected here
          if (mpCnt_ff == 16'h0000)
            mpState_ff <= MP_ON;                                // RL18
          else
            mpCnt_ff <= mpCnt_ff - 16'h0001;
        MP_ON:
          // cs high at the cke rise keeps the mode
          if (ckeRise & !cmd.csN)                               // RL20
          begin
            mpState_ff <= MP_EXIT;                              // RL21
            mpCnt_ff   <= TXMP;
          end
        MP_EXIT:
          if (mpCnt_ff == 16'h0000)
            mpState_ff <= MP_OFF;
          else
            mpCnt_ff <= mpCnt_ff - 16'h0001;
        default:
          mpState_ff <= MP_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // temperature status, sampled once per period while enabled
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tempStat_ff <= 2'h0;
      tempCnt_ff  <= 22'h000000;
    end
    else if (mr3[`DDM_MR3_TEMP])
    begin
      if (tempCnt_ff == 22'h000000)
      begin
        tempStat_ff <= tempRate;                                // RL3
        tempCnt_ff  <= TEMPC;
      end
      else
        tempCnt_ff <= tempCnt_ff - 22'h000001;
    end
    else
      tempCnt_ff <= 22'h000000;                                 // RL4
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdOut_ff     <= '0;
      cmdAccept_ff <= 1'b0;
      ckeLat_ff    <= 1'b0;
      odtLat_ff    <= 1'b0;
      mpsmOn_ff    <= 1'b0;
      exitBusy_ff  <= 1'b0;
    end
    else
    begin
      // status flags trail the state by one clock so pins come from flops
      mpsmOn_ff      <= (mpState_ff == MP_ON);
      exitBusy_ff    <= (xsCnt_ff != 16'h0000) | (mpState_ff == MP_EXIT);
      rdOut_ff.valid <= rdHit;
      if (rdHit)
        rdOut_ff.data <= nxt_rdData;                            // RL1
      cmdAccept_ff <= take;
      if (edgeOk)
      begin
        ckeLat_ff <= cmd.cke;                                   // RL8
        odtLat_ff <= cmd.odt;
      end
    end
  end

  assign rdOut      = rdOut_ff;
  assign gearDown2n = gearOn_ff;
  assign mpsmOn     = mpsmOn_ff;
  assign cmdAccept  = cmdAccept_ff;
  assign ckeLatched = ckeLat_ff;
  assign odtLatched = odtLat_ff;
  assign exitBusy   = exitBusy_ff;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);

  gear_after_wait_a: assert property ( // RL10
    $rose(gearOn_ff) |-> $past(gearWait_ff) && $past(gearCnt_ff) == 16'h0001)
    else $error("2N began without the gear delay");
  gear_fallback_a: assert property ( // RL13
    live && isSre |=> !gearOn_ff && srOn_ff)
    else $error("2N kept through self refresh");
  gear_edge_a: assert property ( // RL8
    cmdAccept_ff && $past(gearOn_ff) |-> $past(phase_ff) == syncPhase_ff)
    else $error("command taken on the wrong 2N edge");
  mpsm_ignore_a: assert property ( // RL17
    mpState_ff == MP_ON |=> !cmdAccept_ff && !rdOut_ff.valid)
    else $error("command taken in power save");
  mpsm_hold_a: assert property ( // RL20
    mpState_ff == MP_ON && ckeRise && cmd.csN |=> mpState_ff == MP_ON)
    else $error("left power save with cs high");
  mpsm_exit_a: assert property ( // RL21
    mpState_ff == MP_ON && ckeRise && !cmd.csN |=> mpState_ff == MP_EXIT)
    else $error("cs low at cke rise did not exit");
  mpsm_clear_a: assert property ( // RL24
    mpDone |=> !mr4[`DDM_MR4_MPSM] && mpState_ff == MP_OFF)
    else $error("power save bit not cleared");
  temp_hold_a: assert property ( // RL4
    !mr3[`DDM_MR3_TEMP] |=> $stable(tempStat_ff))
    else $error("temp status changed while disabled");
  page3_bit_a: assert property ( // RL5
    rdHit && mr3[1:0] == `DDM_PAGE3 |=>
      rdOut_ff.valid && rdOut_ff.data == {7'h00, $past(cmd.ba) != 2'h3})
    else $error("vendor page value wrong");
  sr_exit_a: assert property ( // RL14
    srOn_ff && cmd.cke |=>
      xsCnt_ff == ($past(mr4[`DDM_MR4_ABORT]) ? TXSA : TXS))
    else $error("wrong self refresh exit delay");

  gear_on_c: cover property ($rose(gearOn_ff));
  mpsm_exit_c: cover property (mpDone);
  page2_rd_c: cover property (rdHit && mr3[1:0] == `DDM_PAGE2);
endmodule : ddm_mode_ctrl
`default_nettype wire

// file: verification/ddm_host_model.sv
// controller-side model that drives the command pins of the block
`timescale 1ns/1ps
`default_nettype none
module ddm_host_model (
  input  wire logic              clk,
  output var  ddm_pkg::ddm_cmd_t cmd
);
  import ddm_pkg::*;
  logic ckeLvl = 1'b1;  // clock enable level held by the host
  logic odtLvl = 1'b0;  // termination control level held by the host
  // the bench clock never stops, so it is always valid
  initial cmd = {1'b1, 4'hF, 1'b1, 1'b0, 3'h0, 14'h0000};
  // one command slot, driven just after a rising edge
  task automatic send(input logic [3:0] op, input logic csN,
                      input logic [2:0] mr, input logic [13:0] a);
    @(posedge clk);
    cmd <= {csN, op, ckeLvl, odtLvl, mr, a};
  endtask : send
  // deselect: idle address lines float, shown as a changing pattern
  task automatic des();
    send(4'hF, 1'b1, ~cmd[16:14], ~cmd.addr);
  endtask : des
  task automatic mrs(input logic [2:0] mr, input logic [13:0] a);
    send(4'h8, 1'b0, mr, a);
  endtask : mrs
  task automatic rd(input logic [1:0] ba);
    send(4'hD, 1'b0, {1'b0, ba}, 14'h0000);
  endtask : rd
  task automatic nop();
    send(4'hF, 1'b0, 3'h0, 14'h0000);
  endtask : nop
  // self refresh entry, caller lowers the clock enable first
  task automatic sre();
    send(4'h9, 1'b0, 3'h0, 14'h0000);
  endtask : sre
endmodule : ddm_host_model
`default_nettype wire

// file: verification/tb_ddm_mode_ctrl.sv
// self-checking bench for the mode readout, gear-down and power-save block
`include "ddm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_ddm_mode_ctrl;
  import ddm_pkg::*;
  logic     clk;         // 100 MHz
  logic     reset_n;     // async, active low
  logic [1:0] tempRate;  // sensor refresh code
  ddm_cmd_t cmd;         // command pins from the host model
  ddm_rd_t  rdOut;       // readout answer
  logic     gearDown2n, mpsmOn, cmdAccept, ckeLatched, odtLatched, exitBusy;
  int       mismatches, comparisons, n;
  int       cyc = 0;     // edge count, used for 2N phase
  logic     syncP;       // phase of the sync pulse
  ddm_mode_ctrl #(.TEMP_CYC(8)) dut (
    .clk(clk), .reset_n(reset_n), .cmd(cmd), .tempRate(tempRate),
    .rdOut(rdOut), .gearDown2n(gearDown2n), .mpsmOn(mpsmOn),
    .cmdAccept(cmdAccept), .ckeLatched(ckeLatched),
    .odtLatched(odtLatched), .exitBusy(exitBusy)
  );
  ddm_host_model host (.clk(clk), .cmd(cmd));
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  //////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // the one compare task, for every 8-bit or flag result
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // bounded wait: 0 gear, 1 power save, 2 exit busy
  task automatic waitSig(input int sel, input logic lvl, input int lim,
                         output int cnt);
    cnt = 0;
    while ((sel == 0 ? gearDown2n : sel == 1 ? mpsmOn : exitBusy) !== lvl)
    begin
      host.des();
      #1;
      cnt++;
      if (cnt > lim)
      begin
        mismatches++;
        $display("BAD wait %0d exp %b got timeout", sel, lvl);
        final_report();
      end
    end
  endtask : waitSig
  // read one location, answer is due one edge after the command
  task automatic rd(input logic [1:0] ba, input logic expA, input logic expV,
                    input logic [7:0] exp, input string what);
    host.rd(ba);
    host.des();
    #1;
    chk({what, " accept"}, {7'h0, expA}, {7'h0, cmdAccept});
    chk({what, " valid"}, {7'h0, expV}, {7'h0, rdOut.valid});
    if (expV)
      chk(what, exp, rdOut.data);
  endtask : rd
  task automatic mr(input logic [2:0] m, input logic [13:0] a);
    host.mrs(m, a);
    host.des();
  endtask : mr
  // in 2N the next command must land on the sync phase
  task automatic align();
    host.des();
    while (cyc[0] == syncP)
      host.des();
  endtask : align
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'b0;
    tempRate = 2'h2;
    mismatches = 0;
    comparisons = 0;
    syncP = 1'b0;
    repeat (10) @(posedge clk);
    chk("reset", 8'h00, {5'h0, gearDown2n, mpsmOn, rdOut.valid});
    reset_n <= 1'b1;
    // mirrored settings, temperature sampled as it is enabled
    mr(3'h3, 14'h0026);
    mr(3'h0, 14'h0074);
    mr(3'h1, 14'h0502);
    mr(3'h2, 14'h1628);
    mr(3'h5, 14'h0140);
    mr(3'h6, 14'h0055);
    rd(2'h0, 1'b1, 1'b1, 8'h17, "loc0");
    rd(2'h1, 1'b1, 1'b1, 8'hAA, "loc1");
    rd(2'h2, 1'b1, 1'b1, 8'hF5, "loc2");
    rd(2'h3, 1'b1, 1'b1, 8'hB5, "loc3");
    mr(3'h2, 14'h0000);
    rd(2'h0, 1'b1, 1'b1, 8'h10, "loc0 update");
    @(posedge clk);
    tempRate <= 2'h1;
    repeat (12) host.des();
    rd(2'h0, 1'b1, 1'b1, 8'h08, "temp fresh");
    mr(3'h3, 14'h0006);
    @(posedge clk);
    tempRate <= 2'h3;
    repeat (12) host.des();
    rd(2'h0, 1'b1, 1'b1, 8'h08, "temp frozen");
    mr(3'h3, 14'h0007);
    for (int i = 0; i < 4; i++)
      rd(2'(i), 1'b1, 1'b1, {7'h0, i != 3}, "page3");
    mr(3'h3, 14'h0806);
    rd(2'h0, 1'b1, 1'b0, 8'h00, "serial only");
    $display("test readout done");
    // gear-down: MRS, then sync two edges later
    // additive latency 0, parity and cs latency left off for 2N
    host.mrs(3'h3, 14'h000E);
    host.des();
    host.nop();
    syncP = cyc[0];
    waitSig(0, 1'b1, 40, n);
    chk("gear delay", 8'(`DDM_GEAR_CMD_CYC + 1), n[7:0]);
    align();
    rd(2'h1, 1'b1, 1'b1, 8'hAB, "loc1 gear");
    align();
    host.des();
    host.ckeLvl = 1'b0;
    host.odtLvl = 1'b1;
    rd(2'h1, 1'b0, 1'b0, 8'h00, "off phase");
    chk("pins held", 8'h02, {6'h0, ckeLatched, odtLatched});
    host.ckeLvl = 1'b1;
    host.odtLvl = 1'b0;
    host.des();
    #1;
    chk("pins taken", 8'h01, {6'h0, ckeLatched, odtLatched});
    $display("test gear-down done");
    // self refresh with normal and abort exit times
    for (int i = 0; i < 2; i++)
    begin
      if (i == 1)
        mr(3'h4, 14'h0200);
      align();
      host.ckeLvl = 1'b0;
      host.sre();
      repeat (3) host.des();
      #1;
      chk("sr 1N", 8'h00, {7'h0, gearDown2n});
      host.ckeLvl = 1'b1;
      waitSig(2, 1'b1, 4, n);
      waitSig(2, 1'b0, 40, n);
      chk("sr exit", i ? 8'(`DDM_CYC(`DDM_TXSA_NS)) :
          8'(`DDM_CYC(`DDM_TXS_NS)), n[7:0]);
    end
    $display("test self refresh done");
    // maximum power saving
    mr(3'h3, 14'h0006);
    mr(3'h4, 14'h0002);
    waitSig(1, 1'b1, 10, n);
    rd(2'h0, 1'b0, 1'b0, 8'h00, "ignored");
    host.ckeLvl = 1'b0;
    host.des();
    host.ckeLvl = 1'b1;
    repeat (3) host.des();
    #1;
    chk("stay", 8'h02, {6'h0, mpsmOn, exitBusy});
    host.ckeLvl = 1'b0;
    host.des();
    host.ckeLvl = 1'b1;
    host.nop();
    waitSig(2, 1'b1, 4, n);
    waitSig(1, 1'b0, 30, n);
    waitSig(2, 1'b0, 30, n);
    repeat (15) host.des();
    #1;
    chk("no reentry", 8'h00, {6'h0, mpsmOn, dut.mr4[`DDM_MR4_MPSM]});
    rd(2'h1, 1'b1, 1'b1, 8'hAA, "after exit");
    $display("test power save done");
    final_report();
  end
endmodule : tb_ddm_mode_ctrl
`default_nettype wire
